// ===== pkg/gpep_pkg.sv
// Package for the 8-bit GPIO port with edge detection: offsets, resets, widths
`default_nettype none
package gpep_pkg;
  localparam int GPEP_W = 8;
  // Register word offsets (byte addresses)
  localparam logic [5:0] OFS_PIN_LEVEL = 6'h00;
  localparam logic [5:0] OFS_DIRECTION = 6'h04;
  localparam logic [5:0] OFS_OUT_LATCH = 6'h08;
  localparam logic [5:0] OFS_ANALOG_SEL = 6'h0C;
  localparam logic [5:0] OFS_WEAK_PULLUP = 6'h10;
  localparam logic [5:0] OFS_OPEN_DRAIN = 6'h14;
  localparam logic [5:0] OFS_SLEW_LIMIT = 6'h18;
  localparam logic [5:0] OFS_IN_THRESH = 6'h1C;
  localparam logic [5:0] OFS_RISE_EN = 6'h20;
  localparam logic [5:0] OFS_FALL_EN = 6'h24;
  localparam logic [5:0] OFS_EDGE_FLAGS = 6'h28;
  localparam logic [5:0] OFS_EDGE_CTRL = 6'h2C;
  // Edge control register fields
  localparam int BIT_MASTER_EN = 0;
  localparam int BIT_SUMMARY = 1;
  // Reset values
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL = 8'hFF;
  localparam logic [7:0] RST_WEAK_PULLUP = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_SLEW_LIMIT = 8'hFF;
  localparam logic [7:0] RST_IN_THRESH = 8'hFF;
  localparam logic [7:0] RST_EDGE_EN = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage : gpep_pkg
`default_nettype wire

// ===== src/gpep_port.sv
// GPIO port with per-pin pad control, edge flags and Wishbone register access
//
// Contract
// [R1] Eight pins; direction bit 1 puts the pin driver in high impedance.
// [R2] Direction bit 0 drives the pin from its output latch.
// [R3] Pin value read returns pin levels; write goes to the output latch.
// [R4] Pin value write is read-modify-write into the output latch.
// [R5] Output latch holds the latest write via either latch or pin register.
// [R6] Direction controls drivers even for analog pins; software keeps them input.
// [R7] Threshold select picks Schmitt or TTL input for reads and edges.
// [R8] Software changes thresholds only with peripherals disabled.
// [R9] Open-drain bit makes output sink only; clear gives push-pull.
// [R10] Two-wire peripheral control forces the pin open-drain.
// [R11] Slew bit set limits slew rate; clear gives maximum rate, per pin.
// [R12] Analog select makes every digital read of that pin return zero.
// [R13] Analog select leaves digital output driving unchanged.
// [R14] Analog select resets to analog; software clears before digital input.
// [R15] Per-pin weak pull-up enable, independent for each pin.
// [R16] After reset each pin output comes from its latch; routing may override.
// [R17] Per-pin rising and falling detectors with own enables, both allowed.
// [R18] Enabled edge sets pin flag; interrupt only with master enable set.
// [R19] Master enable clear: flags still set, no interrupt raised.
// [R20] Summary flag is set whenever any pin flag is set.
// [R21] Flags clear on zero write; a coincident edge leaves the flag set.
// [R22] Software clears flags by masking only known changed bits.
// [R23] Edge interrupt wakes the device from sleep when master enable set.
// [R24] Pins are synchronised and edges found from consecutive samples.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`default_nettype none
module gpep_port
  import gpep_pkg::*;
(
  input wire logic SYS_CLK_I, // System clock, 40 MHz
  input wire logic SRST_I, // Synchronous reset, active high
  input wire logic [5:0] ADR_I, // Wishbone byte address
  input wire logic [31:0] DAT_I, // Wishbone write data
  output logic [31:0] DAT_O, // Wishbone read data
  input wire logic WE_I, // Wishbone write enable
  input wire logic [3:0] SEL_I, // Wishbone byte selects
  input wire logic CYC_I, // Wishbone cycle
  input wire logic STB_I, // Wishbone strobe
  output logic ACK_O, // Wishbone acknowledge
  output logic ERR_O, // Wishbone error, unmapped address
  input wire logic [7:0] PAD_ST_I, // Pad levels through Schmitt receivers
  input wire logic [7:0] PAD_TTL_I, // Pad levels through TTL receivers
  output logic [7:0] PAD_O, // Pad output value
  output logic [7:0] PAD_OE_O, // Pad output enable, high drives
  output logic [7:0] PULLUP_EN_O, // Weak pull-up enables
  output logic [7:0] SLEW_LIMIT_O, // Slew-limited drive selects
  output logic [7:0] ANALOG_EN_O, // Analog function select
  input wire logic [7:0] ALT_SEL_I, // Routed peripheral owns the pin
  input wire logic [7:0] ALT_OUT_I, // Routed peripheral output value
  input wire logic [7:0] ALT_OE_I, // Routed peripheral drive request
  input wire logic [7:0] TWI_OWN_I, // Two-wire serial peripheral owns the pin
  input wire logic SLEEP_I, // Device is in sleep state
  output logic EDGE_IRQ_O, // Edge interrupt request
  output logic WAKE_O // Wake request from sleep
);

  // Pad input synchronisers, first stage read only by the second
  logic [7:0] st_meta_ff; // Schmitt view, first stage
  logic [7:0] st_sync_ff; // Schmitt view, settled
  logic [7:0] ttl_meta_ff; // TTL view, first stage
  logic [7:0] ttl_sync_ff; // TTL view, settled
  logic [7:0] lvl_prev_ff; // Level one sample ago
  logic prev_valid_ff; // Previous sample is real
  // Software registers
  logic [7:0] dir_ff;
  logic [7:0] lat_ff;
  logic [7:0] ans_ff;
  logic [7:0] wpu_ff;
  logic [7:0] odc_ff;
  logic [7:0] slr_ff;
  logic [7:0] inl_ff;
  logic [7:0] rise_en_ff;
  logic [7:0] fall_en_ff;
  logic [7:0] flag_ff; // Sticky per-pin edge flags
  logic master_en_ff;
  // Bus answer registers
  logic ack_ff;
  logic err_ff;
  logic [31:0] dat_ff;
  // Output registers
  logic [7:0] pad_o_ff;
  logic [7:0] pad_oe_ff;
  logic [7:0] pu_ff;
  logic [7:0] slew_ff;
  logic [7:0] ana_ff;
  logic irq_ff;
  logic wake_ff;

  // Byte lane 0 carries all register data
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd,
                                            input logic lane);
    merge_byte = lane ? wd[7:0] : old_v;
  endfunction : merge_byte

  // Bus decode
  wire logic req = CYC_I & STB_I & ~ack_ff & ~err_ff;
  wire logic hit_pin = ADR_I == OFS_PIN_LEVEL;
  wire logic hit_dir = ADR_I == OFS_DIRECTION;
  wire logic hit_lat = ADR_I == OFS_OUT_LATCH;
  wire logic hit_ans = ADR_I == OFS_ANALOG_SEL;
  wire logic hit_wpu = ADR_I == OFS_WEAK_PULLUP;
  wire logic hit_odc = ADR_I == OFS_OPEN_DRAIN;
  wire logic hit_slr = ADR_I == OFS_SLEW_LIMIT;
  wire logic hit_inl = ADR_I == OFS_IN_THRESH;
  wire logic hit_rise = ADR_I == OFS_RISE_EN;
  wire logic hit_fall = ADR_I == OFS_FALL_EN;
  wire logic hit_flag = ADR_I == OFS_EDGE_FLAGS;
  wire logic hit_ctrl = ADR_I == OFS_EDGE_CTRL;
  wire logic mapped = hit_pin | hit_dir | hit_lat | hit_ans | hit_wpu | hit_odc | hit_slr
                      | hit_inl | hit_rise | hit_fall | hit_flag | hit_ctrl;
  wire logic wr = req & WE_I & mapped & SEL_I[0];

  // Per-register write strobes
  wire logic wr_pin = wr & hit_pin;
  wire logic wr_dir = wr & hit_dir;
  wire logic wr_lat = wr & hit_lat;
  wire logic wr_ans = wr & hit_ans;
  wire logic wr_wpu = wr & hit_wpu;
  wire logic wr_odc = wr & hit_odc;
  wire logic wr_slr = wr & hit_slr;
  wire logic wr_inl = wr & hit_inl;
  wire logic wr_rise = wr & hit_rise;
  wire logic wr_fall = wr & hit_fall;
  wire logic wr_flag = wr & hit_flag;
  wire logic wr_ctrl = wr & hit_ctrl;

  // [R7] Threshold selects receiver
  wire logic [7:0] level = (inl_ff & st_sync_ff) | (~inl_ff & ttl_sync_ff);
  // [R12] Analog pins read zero
  wire logic [7:0] dig_level = level & ~ans_ff;

  // [R24] Sample to sample edge compare
  wire logic [7:0] rise = prev_valid_ff ? (dig_level & ~lvl_prev_ff) : RST_ZERO;
  wire logic [7:0] fall = prev_valid_ff ? (~dig_level & lvl_prev_ff) : RST_ZERO;
  // [R17] Independent edge enables
  wire logic [7:0] edge_hit = (rise & rise_en_ff) | (fall & fall_en_ff);

  // [R21] Set wins over zero write
  wire logic [7:0] flag_wr = wr_flag ? (flag_ff & DAT_I[7:0]) : flag_ff;
  // [R18] Enabled edge sets flag
  wire logic [7:0] nxt_flag = flag_wr | edge_hit;
  // [R20] Summary of all flags
  wire logic summary = |flag_ff;

  // [R4] Pin write lands in latch; bits outside the byte lane keep their value
  wire logic [7:0] nxt_lat = (wr_pin | wr_lat) ? merge_byte(lat_ff, DAT_I, SEL_I[0])
                                                      : lat_ff;

  // Output source: latch by default, routed peripheral when selected
  // [R16] Latch is default source
  wire logic [7:0] src_val = (ALT_SEL_I & ALT_OUT_I) | (~ALT_SEL_I & lat_ff);
  // [R6] Direction gates driver, analog or not
  wire logic [7:0] drv_req = (ALT_SEL_I & ALT_OE_I) | (~ALT_SEL_I & ~dir_ff);
  // [R10] Two-wire ownership forces open-drain
  wire logic [7:0] od_mode = odc_ff | TWI_OWN_I;
  // [R9] Open-drain drives only lows
  wire logic [7:0] nxt_oe = drv_req & ~(od_mode & src_val);
  wire logic [7:0] nxt_pad = src_val & ~od_mode;

  // Read mux
  wire logic [7:0] rd_byte =
      hit_pin ? dig_level :
      hit_dir ? dir_ff :
      hit_lat ? lat_ff :
      hit_ans ? ans_ff :
      hit_wpu ? wpu_ff :
      hit_odc ? odc_ff :
      hit_slr ? slr_ff :
      hit_inl ? inl_ff :
      hit_rise ? rise_en_ff :
      hit_fall ? fall_en_ff :
      hit_flag ? flag_ff :
      hit_ctrl ? {6'h00, summary, master_en_ff} : RST_ZERO;

  // Two-stage synchronisers
  always_ff @(posedge SYS_CLK_I) begin
    st_meta_ff <= PAD_ST_I;
    st_sync_ff <= st_meta_ff;
    ttl_meta_ff <= PAD_TTL_I;
    ttl_sync_ff <= ttl_meta_ff;
  end

  // Previous sample; first sample after reset gives no edge
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      lvl_prev_ff <= RST_ZERO;
      prev_valid_ff <= 1'b0;
    end else begin
      lvl_prev_ff <= dig_level;
      prev_valid_ff <= 1'b1;
    end
  end

  // [R14] Analog select resets set, so pins start analog
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ans_ff <= RST_ANALOG_SEL;
    end else if (wr_ans) begin
      ans_ff <= DAT_I[7:0];
    end
  end

  // [R1] Direction register, set means input
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      dir_ff <= RST_DIRECTION;
    end else if (wr_dir) begin
      dir_ff <= DAT_I[7:0];
    end
  end

  // [R15] Pull-up enables per pin
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      wpu_ff <= RST_WEAK_PULLUP;
    end else if (wr_wpu) begin
      wpu_ff <= DAT_I[7:0];
    end
  end

  // Open-drain selects; two-wire ownership is merged in later
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      odc_ff <= RST_OPEN_DRAIN;
    end else if (wr_odc) begin
      odc_ff <= DAT_I[7:0];
    end
  end

  // [R11] Slew selects per pin
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      slr_ff <= RST_SLEW_LIMIT;
    end else if (wr_slr) begin
      slr_ff <= DAT_I[7:0];
    end
  end

  // Threshold selects; a change can fake an edge, software picks the moment
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      inl_ff <= RST_IN_THRESH;
    end else if (wr_inl) begin
      inl_ff <= DAT_I[7:0];
    end
  end

  // [R5] Latest latch or pin write; pins are not sampled, so floating ones cannot leak in
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      lat_ff <= RST_OUT_LATCH;
    end else begin
      lat_ff <= nxt_lat;
    end
  end

  // Edge flags, clear and set already merged
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      flag_ff <= RST_ZERO;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // Rising edge enables
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      rise_en_ff <= RST_EDGE_EN;
    end else if (wr_rise) begin
      rise_en_ff <= DAT_I[7:0];
    end
  end

  // Falling edge enables
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      fall_en_ff <= RST_EDGE_EN;
    end else if (wr_fall) begin
      fall_en_ff <= DAT_I[7:0];
    end
  end

  // Master interrupt enable; the summary bit beside it is read only
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      master_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
      master_en_ff <= DAT_I[BIT_MASTER_EN];
    end
  end

  // Bus answer one cycle after request; unmapped gives error
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & mapped;
      err_ff <= req & ~mapped;
      // [R3] Pin read returns levels
      dat_ff <= (req & ~WE_I & mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Registered pad outputs and configuration copies
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      pad_o_ff <= RST_ZERO;
      pad_oe_ff <= RST_ZERO;
      pu_ff <= RST_WEAK_PULLUP;
      slew_ff <= RST_SLEW_LIMIT;
      ana_ff <= RST_ANALOG_SEL;
    end else begin
      // [R2] Driver enabled from direction, driven from latch
      // [R13] Analog select not in drive path
      pad_o_ff <= nxt_pad;
      pad_oe_ff <= nxt_oe;
      pu_ff <= wpu_ff;
      slew_ff <= slr_ff;
      ana_ff <= ans_ff;
    end
  end

  // Interrupt outputs, one cycle behind the flags
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      // [R19] Master enable gates interrupt only
      irq_ff <= summary & master_en_ff;
      // [R23] Wake on edge interrupt in sleep
      wake_ff <= summary & master_en_ff & SLEEP_I;
    end
  end

  assign DAT_O = dat_ff;
  assign ACK_O = ack_ff;
  assign ERR_O = err_ff;
  assign PAD_O = pad_o_ff;
  assign PAD_OE_O = pad_oe_ff;
  assign PULLUP_EN_O = pu_ff;
  assign SLEW_LIMIT_O = slew_ff;
  assign ANALOG_EN_O = ana_ff;
  assign EDGE_IRQ_O = irq_ff;
  assign WAKE_O = wake_ff;

endmodule : gpep_port
`default_nettype wire

// ===== tb/gpep_board.sv
// Board model: pads, external driver, pull-ups and two receiver views
`default_nettype none
module gpep_board (
  input wire logic clk_i, // System clock
  input wire logic [7:0] pad_i, // Device pad value
  input wire logic [7:0] oe_i, // Device drive enables
  input wire logic [7:0] pu_i, // Weak pull-ups
  input wire logic [7:0] ext_i, // Board driver value
  input wire logic [7:0] ext_en_i, // Board driver enables
  input wire logic [7:0] mid_i, // Level between thresholds
  output logic [7:0] st_o, // Schmitt view
  output logic [7:0] ttl_o // TTL view
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_ff = 8'h00;
  // pad level: driver first, then board, then pull-up
  // A floating pin wanders each cycle so no stale level is read back
  assign st_o = (oe_i & pad_i) | (~oe_i & ext_en_i & ext_i)
                | (~oe_i & ~ext_en_i & (pu_i | ~last_ff));
  // mid-level pins look inverted to the TTL receiver
  assign ttl_o = st_o ^ mid_i;
  always_ff @(posedge clk_i) begin
    last_ff <= st_o;
  end
endmodule : gpep_board
`default_nettype wire

// ===== tb/gpep_port_monitor.sv
// Checker for bus answers, pad drive, wake and reset state
`default_nettype none
module gpep_port_monitor
  import gpep_pkg::*;
(
  input wire logic SYS_CLK_I, // Clock
  input wire logic SRST_I, // Reset
  input wire logic CYC_I, // Cycle
  input wire logic STB_I, // Strobe
  input wire logic ACK_O, // Ack
  input wire logic ERR_O, // Error
  input wire logic [31:0] DAT_O, // Read data
  input wire logic [7:0] PAD_O, // Pad value
  input wire logic [7:0] PAD_OE_O, // Pad enable
  input wire logic [7:0] SLEW_LIMIT_O, // Slew
  input wire logic [7:0] ANALOG_EN_O, // Analog
  input wire logic [7:0] TWI_OWN_I, // Two-wire owner
  input wire logic SLEEP_I, // Sleep
  input wire logic EDGE_IRQ_O, // Interrupt
  input wire logic WAKE_O // Wake
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // Pending request, then its one-cycle answer
  sequence s_req;
    CYC_I && STB_I && !ACK_O && !ERR_O;
  endsequence
  sequence s_ans;
    ACK_O || ERR_O;
  endsequence
  a_ack_next: assert property (s_req |=> s_ans)
    else $error("bus answer missing");
  a_ack_pulse: assert property (s_ans |=> !(ACK_O || ERR_O))
    else $error("bus answer too long");
  a_ack_excl: assert property (!(ACK_O && ERR_O))
    else $error("ack and error together");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside ack");
  a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  // Two-wire owned pins may only pull low
  a_twi_sink: assert property (($past(TWI_OWN_I) & PAD_OE_O & PAD_O) == 8'h00)
    else $error("two-wire pin driven high");
  a_wake_sleep: assert property (WAKE_O == (EDGE_IRQ_O && $past(SLEEP_I)))
    else $error("wake mismatch");
  a_reset_vals: assert property ($past(SRST_I) |-> SLEW_LIMIT_O == RST_SLEW_LIMIT
    && ANALOG_EN_O == RST_ANALOG_SEL && PAD_OE_O == 8'h00)
    else $error("reset state wrong");
endmodule : gpep_port_monitor
bind gpep_port gpep_port_monitor u_gpep_port_monitor (.*);
`default_nettype wire

// ===== tb/gpep_port_tb.sv
// Self-checking bench for the GPIO port with edge flags
`default_nettype none
module gpep_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] a; logic [7:0] r, w, e;} gpep_row_s;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, lerr;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, q;
  logic [7:0] twi = 8'h00, ev = 8'h00, een = 8'hFF, mid = 8'h00;
  logic [7:0] alt_sel = 8'h00, alt_out = 8'h00, alt_oe = 8'h00;
  logic [3:0] sel = 4'hF;
  wire logic [31:0] rdat;
  wire logic ack, err, irq, wake;
  wire logic [7:0] po, poe, pu, slw, ana, st, ttl;
  int fail_count = 0, num_checks = 0;
  // Reset value, write value, readback; flag writes never set
  gpep_row_s rows [11] = '{'{6'h04, 8'hFF, 8'hA5, 8'hA5}, '{6'h08, 8'h00, 8'h3C, 8'h3C},
    '{6'h0C, 8'hFF, 8'h0F, 8'h0F}, '{6'h10, 8'h00, 8'h81, 8'h81}, '{6'h14, 8'h00, 8'h42, 8'h42},
    '{6'h18, 8'hFF, 8'h5A, 8'h5A}, '{6'h1C, 8'hFF, 8'hC3, 8'hC3}, '{6'h20, 8'h00, 8'h11, 8'h11},
    '{6'h24, 8'h00, 8'h22, 8'h22}, '{6'h28, 8'h00, 8'hFF, 8'h00}, '{6'h2C, 8'h00, 8'h01, 8'h01}};
  always #12.5 clk = ~clk;
  gpep_port u_gpep_port (.SYS_CLK_I(clk), .SRST_I(rst), .ADR_I(adr), .DAT_I(wd), .DAT_O(rdat),
    .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .ERR_O(err),
    .PAD_ST_I(st), .PAD_TTL_I(ttl), .PAD_O(po), .PAD_OE_O(poe), .PULLUP_EN_O(pu),
    .SLEW_LIMIT_O(slw), .ANALOG_EN_O(ana), .ALT_SEL_I(alt_sel), .ALT_OUT_I(alt_out),
    .ALT_OE_I(alt_oe), .TWI_OWN_I(twi), .SLEEP_I(slp), .EDGE_IRQ_O(irq), .WAKE_O(wake));
  gpep_board u_gpep_board (.clk_i(clk), .pad_i(po), .oe_i(poe), .pu_i(pu), .ext_i(ev),
    .ext_en_i(een), .mid_i(mid), .st_o(st), .ttl_o(ttl));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One classic cycle; waits for the answer, bounded by the watchdog
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    lerr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Main sequence: table first, then hand-written cases
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({pu, slw, ana}, 32'h00FFFF);
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].r);
      wb(1'b1, rows[i].a, {24'h0, rows[i].w});
      rd(rows[i].a, rows[i].e);
    end
    chk({pu, slw, ana}, 32'h815A0F);
    // Write without byte lane 0 is acknowledged and ignored
    sel <= 4'h0;
    wb(1'b1, 6'h04, 32'h00);
    sel <= 4'hF;
    rd(6'h04, 8'hA5);
    wb(1'b1, 6'h30, 32'hFF);
    chk(lerr, 32'h1);
    $display("register test done");
    wb(1'b1, 6'h0C, 32'h00);
    // pins kept as inputs while read
    wb(1'b1, 6'h04, 32'hFF);
    wb(1'b1, 6'h1C, 32'hF0);
    ev <= 8'hA5;
    mid <= 8'hFF;
    repeat (4) @(posedge clk);
    rd(6'h00, 8'hAA);
    wb(1'b1, 6'h0C, 32'h0F);
    rd(6'h00, 8'hA0);
    $display("pin read test done");
    mid <= 8'h00;
    een <= 8'h00;
    wb(1'b1, 6'h00, 32'h96);
    rd(6'h08, 8'h96);
    // Push-pull on every pin before the drive check
    wb(1'b1, 6'h14, 32'h00);
    wb(1'b1, 6'h04, 32'h00);
    @(negedge clk);
    chk({po, poe}, 32'h96FF);
    @(posedge clk);
    wb(1'b1, 6'h14, 32'h0F);
    @(negedge clk);
    chk(poe, 32'hF9);
    @(posedge clk);
    twi <= 8'hF0;
    repeat (2) @(negedge clk);
    chk(poe, 32'h69);
    @(posedge clk);
    twi <= 8'h00;
    // routed peripheral takes the two upper pins
    alt_sel <= 8'hC0;
    alt_out <= 8'h40;
    alt_oe <= 8'h80;
    repeat (2) @(negedge clk);
    chk({po, poe}, 32'h50B9);
    @(posedge clk);
    alt_sel <= 8'h00;
    wb(1'b1, 6'h04, 32'hFF);
    @(negedge clk);
    chk(poe, 32'h00);
    @(posedge clk);
    $display("pad drive test done");
    een <= 8'hFF;
    ev <= 8'h00;
    wb(1'b1, 6'h0C, 32'h00);
    wb(1'b1, 6'h20, 32'h05);
    wb(1'b1, 6'h24, 32'h06);
    wb(1'b1, 6'h2C, 32'h00);
    wb(1'b1, 6'h28, 32'h00);
    ev <= 8'h07;
    repeat (5) @(posedge clk);
    rd(6'h28, 8'h05);
    rd(6'h2C, 8'h02);
    chk(irq, 32'h0);
    ev <= 8'h00;
    repeat (5) @(posedge clk);
    rd(6'h28, 8'h07);
    slp <= 1'b1;
    wb(1'b1, 6'h2C, 32'h01);
    @(negedge clk);
    chk({irq, wake}, 32'h3);
    @(posedge clk);
    wb(1'b1, 6'h28, 32'hF9);
    rd(6'h28, 8'h01);
    // Edge lands on the clearing write
    ev <= 8'h04;
    repeat (2) @(posedge clk);
    wb(1'b1, 6'h28, 32'h00);
    rd(6'h28, 8'h04);
    $display("edge test done");
    report_and_stop();
  end
  // Watchdog, about fourteen times the expected run
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule : gpep_port_tb
`default_nettype wire
